// ### rtl/timer_setup.sv
// Timer setup: register slave, clock enables, pins and interrupts
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
module timer_setup (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic gen_timer_a_gate_clock_in,
   output logic gen_timer_a_output,
   output logic gen_timer_a_pin_lo_oe_n,
   output logic gen_timer_a_pin_hi_oe_n,
   output logic gen_timer_b_output,
   output logic gen_timer_b_pin_lo_oe_n,
   output logic gen_timer_b_pin_hi_oe_n,
   output logic [tmr_pkg::NUM_PWM-1:0] pwm_out,
   output logic [tmr_pkg::NUM_PWM-1:0] pwm_out_oe_n,
   output logic irq
);
   localparam int NT = tmr_pkg::NUM_TIMERS;
   localparam int CW = tmr_pkg::CNT_W;
   if (tmr_pkg::PS_MAX >= (1 << tmr_pkg::PS_W)) begin : g_chk
      $error("timer_setup: prescale field too narrow");
   end
   logic [tmr_pkg::CTRL_W-1:0] ctrl_q [NT];
   logic [CW-1:0] rise_q [NT];
   logic [CW-1:0] fall_q [NT];
   logic [CW-1:0] count_w [NT];
   logic [31:0] ctrl_rd [NT];
   logic [NT-1:0] en_w, run_w, out_w, rev_w, fev_w, rie_w, fie_w, drive_w;
   logic [tmr_pkg::STAT_W-1:0] stat_q, mask_q, ev_w, clr_w;
   logic [tmr_pkg::PM_W-1:0] pinmux_q;
   logic [tmr_pkg::ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q, wmask, t_word, g_word, rd_word;
   logic [3:0] wstrb_q;
   logic [1:0] tick_w;
   logic gate_q;
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [31:0] m);
      return (old & ~m) | (nw & m);
   endfunction
   // ------------------------------------------------------------
   // Peripheral and double rate clock enables
   // ------------------------------------------------------------
   // Fractional divider: 2 of 5 and 4 of 5 system cycles tick
   for (genvar k = 0; k < 2; k++) begin : g_rate
      logic [tmr_pkg::ACC_W-1:0] acc_q;
      logic tick_q;
      wire [tmr_pkg::ACC_W:0] sum = {1'b0, acc_q} +
         (k == 0 ? tmr_pkg::STEP_STD : tmr_pkg::STEP_FAST);
      wire wrap = sum >= tmr_pkg::ACC_MOD;
      wire [tmr_pkg::ACC_W:0] sub = sum - tmr_pkg::ACC_MOD;
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            acc_q <= '0;
            tick_q <= 1'b0;
         end else begin
            acc_q <= wrap ? sub[tmr_pkg::ACC_W-1:0] : sum[tmr_pkg::ACC_W-1:0];
            tick_q <= wrap;
         end
      end
      assign tick_w[k] = tick_q;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         gate_q <= 1'b0;
      else
         gate_q <= gen_timer_a_gate_clock_in;
   end
   wire ext_tick = gen_timer_a_gate_clock_in && !gate_q;
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire [3:0] w_blk = awaddr_q[tmr_pkg::BLK_LO +: 4];
   wire [1:0] w_reg = awaddr_q[tmr_pkg::REG_LO +: 2];
   wire [3:0] r_blk = s_axi_araddr[tmr_pkg::BLK_LO +: 4];
   wire [1:0] r_reg = s_axi_araddr[tmr_pkg::REG_LO +: 2];
   wire [15:0] en_pad = 16'(en_w);
   // Touching a powered-down timer beyond its control word is refused
   // Enables go in as an argument so the decode follows them at once
   function automatic logic acc_err(input logic [3:0] b,
      input logic [1:0] r, input logic [15:0] en);
      return (b > tmr_pkg::GLOBAL_BLK) ||
         (b == tmr_pkg::GLOBAL_BLK && r == tmr_pkg::G_RSVD) ||
         (b < tmr_pkg::GLOBAL_BLK && r != tmr_pkg::REG_CTRL && !en[b]);
   endfunction
   wire w_err = acc_err(w_blk, w_reg, en_pad);
   wire r_err = acc_err(r_blk, r_reg, en_pad);
   wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire wr_ok = wr_go && !w_err;
   wire wr_glob = wr_ok && w_blk == tmr_pkg::GLOBAL_BLK;
   wire [3:0] r_idx = (r_blk < tmr_pkg::GLOBAL_BLK) ? r_blk : '0;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
      {8{wstrb_q[0]}}};
   assign t_word = (r_reg == tmr_pkg::REG_CTRL) ? ctrl_rd[r_idx] :
      (r_reg == tmr_pkg::REG_RISE) ? 32'(rise_q[r_idx]) :
      (r_reg == tmr_pkg::REG_FALL) ? 32'(fall_q[r_idx]) :
      32'(count_w[r_idx]);
   assign g_word = (r_reg == tmr_pkg::G_STAT) ? 32'(stat_q) :
      (r_reg == tmr_pkg::G_MASK) ? 32'(mask_q) : 32'(pinmux_q);
   assign rd_word = r_err ? '0 :
      (r_blk == tmr_pkg::GLOBAL_BLK) ? g_word : t_word;
   // ------------------------------------------------------------
   // AXI4-Lite channels
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready)
         s_axi_awready <= 1'b1;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b1;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready)
         s_axi_wready <= 1'b1;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tmr_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= w_err ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
      end else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= tmr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= r_err ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Per-timer registers and cores
   // ------------------------------------------------------------
   for (genvar i = 0; i < NT; i++) begin : g_tim
      localparam bit EXT_OK = (i == tmr_pkg::IDX_GEN_A);
      localparam bit FAST_OK = (i >= tmr_pkg::IDX_PWM_FIRST) &&
         (i <= tmr_pkg::IDX_PWM_LAST) && (i != tmr_pkg::IDX_NO_FAST);
      localparam bit AUTO_PIN = (i >= tmr_pkg::IDX_PWM_FIRST) &&
         (i <= tmr_pkg::IDX_PWM_AUTO_LAST);
      localparam bit HAS_PIN = (i != tmr_pkg::IDX_HELPER);
      wire sel = wr_ok && w_blk == 4'(i);
      wire wr_c = sel && w_reg == tmr_pkg::REG_CTRL;
      wire [31:0] cw = merge(32'(ctrl_q[i]), wdata_q, wmask);
      wire [tmr_pkg::PS_W-1:0] ps_new = cw[tmr_pkg::CB_PS_HI:tmr_pkg::CB_PS_LO];
      // Out-of-range prescale is ignored, the old one stays
      wire ps_ok = ps_new <= tmr_pkg::PS_W'(tmr_pkg::PS_MAX);
      wire ext_ok = EXT_OK && ctrl_q[i][tmr_pkg::CB_EN];
      wire [tmr_pkg::CTRL_W-1:0] ctrl_d = {
         ps_ok ? ps_new : ctrl_q[i][tmr_pkg::CB_PS_HI:tmr_pkg::CB_PS_LO],
         cw[tmr_pkg::CB_FAST] && FAST_OK,
         cw[tmr_pkg::CB_EXT] && ext_ok,
         cw[tmr_pkg::CB_FIE:tmr_pkg::CB_REP], 1'b0, cw[tmr_pkg::CB_EN]};
      wire [31:0] rw = merge(32'(rise_q[i]), wdata_q, wmask);
      wire [31:0] fw = merge(32'(fall_q[i]), wdata_q, wmask);
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            ctrl_q[i] <= '0;
            rise_q[i] <= '0;
            fall_q[i] <= '0;
         end else begin
            if (wr_c)
               ctrl_q[i] <= ctrl_d;
            if (sel && w_reg == tmr_pkg::REG_RISE)
               rise_q[i] <= rw[CW-1:0];
            if (sel && w_reg == tmr_pkg::REG_FALL)
               fall_q[i] <= fw[CW-1:0];
         end
      end
      assign en_w[i] = ctrl_q[i][tmr_pkg::CB_EN];
      assign rie_w[i] = ctrl_q[i][tmr_pkg::CB_RIE];
      assign fie_w[i] = ctrl_q[i][tmr_pkg::CB_FIE];
      assign ctrl_rd[i] = 32'(ctrl_q[i]) | (32'(run_w[i]) << tmr_pkg::CB_RUN);
      // PWM indexes 2-4 route their own pin; the rest need the mux grant
      assign drive_w[i] = HAS_PIN && en_w[i] && ctrl_q[i][tmr_pkg::CB_OUT] &&
         (AUTO_PIN || pinmux_q[i]);
      timer_core u_core (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .enable(en_w[i]),
         .base_tick(tick_w[0]),
         .fast_tick(tick_w[1]),
         .fast_sel(ctrl_q[i][tmr_pkg::CB_FAST]),
         .ext_sel(ctrl_q[i][tmr_pkg::CB_EXT]),
         .ext_tick(ext_tick),
         .prescale(ctrl_q[i][tmr_pkg::CB_PS_HI:tmr_pkg::CB_PS_LO]),
         .start(wr_c && cw[tmr_pkg::CB_RUN] && cw[tmr_pkg::CB_EN]),
         .stop(wr_c && !cw[tmr_pkg::CB_RUN]),
         .repeat_mode(ctrl_q[i][tmr_pkg::CB_REP]),
         .rise_count(rise_q[i]),
         .fall_count(fall_q[i]),
         .count_q(count_w[i]),
         .out_q(out_w[i]),
         .rise_ev_q(rev_w[i]),
         .fall_ev_q(fev_w[i]),
         .running_q(run_w[i])
      );
      if (!EXT_OK) begin : g_noext
         a_ext_only_a: assert property (@(posedge sys_clk) disable iff
            (!rst_n) !ctrl_q[i][tmr_pkg::CB_EXT])
            else $error("gate clock selected on a timer without one");
      end
      a_ps_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
         ctrl_q[i][tmr_pkg::CB_PS_HI:tmr_pkg::CB_PS_LO] <=
         tmr_pkg::PS_W'(tmr_pkg::PS_MAX))
         else $error("prescale above limit");
      a_rise_sticky: assert property (@(posedge sys_clk) disable iff
         (!rst_n) rev_w[i] && rie_w[i] |=> stat_q[i])
         else $error("enabled rise event not latched");
   end
   // ------------------------------------------------------------
   // Interrupt status, mask, pin mux
   // ------------------------------------------------------------
   assign ev_w = {fev_w & fie_w, rev_w & rie_w};
   assign clr_w = (wr_glob && w_reg == tmr_pkg::G_STAT) ?
      tmr_pkg::STAT_W'(wdata_q & wmask) : '0;
   wire [31:0] mw = merge(32'(mask_q), wdata_q, wmask);
   wire [31:0] pw = merge(32'(pinmux_q), wdata_q, wmask);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= '0;
         mask_q <= '0;
         pinmux_q <= '0;
         irq <= 1'b0;
      end else begin
         // A new event beats a clear in the same cycle
         stat_q <= (stat_q & ~clr_w) | ev_w;
         if (wr_glob && w_reg == tmr_pkg::G_MASK)
            mask_q <= mw[tmr_pkg::STAT_W-1:0];
         if (wr_glob && w_reg == tmr_pkg::G_PINMUX)
            pinmux_q <= pw[tmr_pkg::PM_W-1:0];
         irq <= |(stat_q & mask_q);
      end
   end
   // ------------------------------------------------------------
   // Pin stage
   // ------------------------------------------------------------
   wire alt_a = pinmux_q[tmr_pkg::PM_ALT_A];
   wire alt_b = pinmux_q[tmr_pkg::PM_ALT_B];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gen_timer_a_output <= 1'b0;
         gen_timer_a_pin_lo_oe_n <= 1'b1;
         gen_timer_a_pin_hi_oe_n <= 1'b1;
         gen_timer_b_output <= 1'b0;
         gen_timer_b_pin_lo_oe_n <= 1'b1;
         gen_timer_b_pin_hi_oe_n <= 1'b1;
         pwm_out <= '0;
         pwm_out_oe_n <= '1;
      end else begin
         gen_timer_a_output <= out_w[tmr_pkg::IDX_GEN_A];
         gen_timer_a_pin_lo_oe_n <= !(drive_w[tmr_pkg::IDX_GEN_A] && !alt_a);
         gen_timer_a_pin_hi_oe_n <= !(drive_w[tmr_pkg::IDX_GEN_A] && alt_a);
         gen_timer_b_output <= out_w[tmr_pkg::IDX_GEN_B];
         gen_timer_b_pin_lo_oe_n <= !(drive_w[tmr_pkg::IDX_GEN_B] && !alt_b);
         gen_timer_b_pin_hi_oe_n <= !(drive_w[tmr_pkg::IDX_GEN_B] && alt_b);
         pwm_out <= out_w[tmr_pkg::IDX_PWM_LAST:tmr_pkg::IDX_PWM_FIRST];
         pwm_out_oe_n <= ~drive_w[tmr_pkg::IDX_PWM_LAST:
            tmr_pkg::IDX_PWM_FIRST];
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_no_fast_five: assert property (
      !ctrl_q[tmr_pkg::IDX_NO_FAST][tmr_pkg::CB_FAST])
      else $error("double rate accepted on index five");
   a_one_pin_a: assert property (
      gen_timer_a_pin_lo_oe_n || gen_timer_a_pin_hi_oe_n)
      else $error("both pins of timer a driven");
   a_auto_pin: assert property (en_w[tmr_pkg::IDX_PWM_FIRST] &&
      ctrl_q[tmr_pkg::IDX_PWM_FIRST][tmr_pkg::CB_OUT]
      |=> !pwm_out_oe_n[0])
      else $error("first PWM pin not driven after enable");
   a_pin_gated: assert property (!gen_timer_a_pin_lo_oe_n |->
      $past(ctrl_q[tmr_pkg::IDX_GEN_A][tmr_pkg::CB_OUT]))
      else $error("timer a pin driven without output enable");
   a_bad_read: assert property (s_axi_arvalid && s_axi_arready && r_err
      |=> s_axi_rvalid && s_axi_rresp == tmr_pkg::RESP_SLVERR)
      else $error("refused read not answered with error");
   a_irq_level: assert property ((|(stat_q & mask_q)) [*2] |-> irq)
      else $error("interrupt not raised for pending status");
   c_rise_irq: cover property (rev_w[tmr_pkg::IDX_GEN_A] ##[1:3] irq);
   c_alt_pin: cover property (!gen_timer_a_pin_hi_oe_n);
   c_wide_cnt: cover property (count_w[tmr_pkg::IDX_PWM_FIRST][CW-1]);
endmodule

// ### rtl/tmr_pkg.sv
// Constants shared by the timer setup block
// Operation
// - Counting clock is peripheral clock over 2^prescale
// - Separate rise and fall interrupt enables
// - Pin driven only with output enable set
// - Timers indexed 0-1 general, 2-7 PWM, 8 helper
// - Disable stops counting and powers timer down
// - PWM indexes 2-4 route own pin on enable
// - Only timer 0 counts gate, after enable
// - PWM timers default 16 MHz, optionally 32 MHz
// - Double rate widens counter to 17 bits
// - Timer index 5 refuses double rate clock
// - Timer 0 output on either of two pins
// - Output starts low, rises, falls at counts
package tmr_pkg;
   // ------------------------------------------------------------
   // Sizes and indexes
   // ------------------------------------------------------------
   localparam int NUM_TIMERS = 9;
   localparam int STAT_W = 2 * NUM_TIMERS;
   localparam int CNT_W = 17;
   localparam int BASE_W = 16;
   localparam int PS_W = 5;
   localparam int PS_MAX = 16;
   localparam int DIV_W = 16;
   localparam int ADDR_W = 8;
   localparam int IDX_GEN_A = 0;
   localparam int IDX_GEN_B = 1;
   localparam int IDX_PWM_FIRST = 2;
   localparam int IDX_PWM_AUTO_LAST = 4;
   localparam int IDX_NO_FAST = 5;
   localparam int IDX_PWM_LAST = 7;
   localparam int IDX_HELPER = 8;
   localparam int NUM_PWM = IDX_PWM_LAST - IDX_PWM_FIRST + 1;
   // ------------------------------------------------------------
   // Clock rates
   // ------------------------------------------------------------
   localparam int SYS_HZ = 40_000_000;
   localparam int PERIPH_HZ = 16_000_000;
   localparam int FAST_HZ = 32_000_000;
   localparam int GRAIN_HZ = 8_000_000;
   localparam int ACC_W = 3;
   localparam logic [ACC_W:0] ACC_MOD = (ACC_W+1)'(SYS_HZ / GRAIN_HZ);
   localparam logic [ACC_W:0] STEP_STD = (ACC_W+1)'(PERIPH_HZ / GRAIN_HZ);
   localparam logic [ACC_W:0] STEP_FAST = (ACC_W+1)'(FAST_HZ / GRAIN_HZ);
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int BLK_LO = 4;
   localparam int REG_LO = 2;
   localparam logic [3:0] GLOBAL_BLK = 4'(NUM_TIMERS);
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_RISE = 2'h1;
   localparam logic [1:0] REG_FALL = 2'h2;
   localparam logic [1:0] REG_COUNT = 2'h3;
   localparam logic [1:0] G_STAT = 2'h0;
   localparam logic [1:0] G_MASK = 2'h1;
   localparam logic [1:0] G_PINMUX = 2'h2;
   localparam logic [1:0] G_RSVD = 2'h3;
   localparam int CTRL_W = 13;
   localparam int CB_EN = 0;
   localparam int CB_RUN = 1;
   localparam int CB_REP = 2;
   localparam int CB_OUT = 3;
   localparam int CB_RIE = 4;
   localparam int CB_FIE = 5;
   localparam int CB_EXT = 6;
   localparam int CB_FAST = 7;
   localparam int CB_PS_LO = 8;
   localparam int CB_PS_HI = CB_PS_LO + PS_W - 1;
   localparam int PM_W = 11;
   localparam int PM_ALT_A = 9;
   localparam int PM_ALT_B = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/timer_core.sv
// One timer: prescaler, counter and output waveform
module timer_core #(
   parameter int CNT_W = tmr_pkg::CNT_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic base_tick,
   input wire logic fast_tick,
   input wire logic fast_sel,
   input wire logic ext_sel,
   input wire logic ext_tick,
   input wire logic [tmr_pkg::PS_W-1:0] prescale,
   input wire logic start,
   input wire logic stop,
   input wire logic repeat_mode,
   input wire logic [CNT_W-1:0] rise_count,
   input wire logic [CNT_W-1:0] fall_count,
   output logic [CNT_W-1:0] count_q,
   output logic out_q,
   output logic rise_ev_q,
   output logic fall_ev_q,
   output logic running_q
);
   if (CNT_W != tmr_pkg::BASE_W + 1) begin : g_chk
      $error("timer_core: counter must be one bit wider than base");
   end
   logic [tmr_pkg::DIV_W-1:0] div_q;
   logic [tmr_pkg::DIV_W-1:0] ps_mask;
   logic [CNT_W-1:0] lim_mask;
   logic [CNT_W-1:0] nxt;
   logic [CNT_W-1:0] rise_m;
   logic [CNT_W-1:0] fall_m;
   logic src;
   logic tick;
   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   assign ps_mask = tmr_pkg::DIV_W'(((CNT_W)'(1) << prescale) - 1'b1);
   assign src = ext_sel ? ext_tick : (fast_sel ? fast_tick : base_tick);
   assign tick = src && ((div_q & ps_mask) == ps_mask);
   // Top bit only counts on the double rate clock
   assign lim_mask = fast_sel ? '1 : {1'b0, {tmr_pkg::BASE_W{1'b1}}};
   assign nxt = (count_q + 1'b1) & lim_mask;
   assign rise_m = rise_count & lim_mask;
   assign fall_m = fall_count & lim_mask;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         div_q <= '0;
      else if (!enable || start)
         div_q <= '0;
      else if (src)
         div_q <= div_q + 1'b1;
   end
   // ------------------------------------------------------------
   // Counter and waveform
   // ------------------------------------------------------------
   // Fall wins when both counts match: the period always closes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         out_q <= 1'b0;
         rise_ev_q <= 1'b0;
         fall_ev_q <= 1'b0;
         running_q <= 1'b0;
      end else begin
         rise_ev_q <= 1'b0;
         fall_ev_q <= 1'b0;
         if (!enable || stop) begin
            running_q <= 1'b0;
            out_q <= 1'b0;
         end else if (start) begin
            running_q <= 1'b1;
            count_q <= '0;
            out_q <= 1'b0;
         end else if (running_q && tick) begin
            if (nxt == fall_m) begin
               out_q <= 1'b0;
               fall_ev_q <= 1'b1;
               count_q <= '0;
               running_q <= repeat_mode;
            end else begin
               count_q <= nxt;
               if (nxt == rise_m) begin
                  out_q <= 1'b1;
                  rise_ev_q <= 1'b1;
               end
            end
         end
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire go = enable && !stop && !start;
   a_stop_halts: assert property (!enable |=> !running_q && !out_q)
      else $error("timer still runs while disabled");
   a_start_low: assert property (enable && !stop && start |=>
      running_q && !out_q && count_q == '0)
      else $error("start did not clear count and output");
   a_rise_high: assert property (rise_ev_q |-> out_q && running_q)
      else $error("rise event without high output");
   a_narrow_cnt: assert property (go && !fast_sel && running_q && tick
      |=> !count_q[CNT_W-1])
      else $error("top count bit used at standard rate");
   a_undivided: assert property (go && running_q && src && prescale == '0
      |=> fall_ev_q || count_q != $past(count_q))
      else $error("prescale zero did not count every tick");
endmodule

// ### dv/timer_setup_test.sv
// Self-checking bench for the timer setup block
module timer_setup_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Signals and design
   // ------------------------------------------------------------
   logic sys_clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdata;
   logic awr, wrdy, bv, arr, rv, ta_o, ta_lo, ta_hi, irq, gate = 0;
   logic [8:0] idle_pins;
   logic [1:0] bresp, rresp;
   logic [5:0] pwm_oe_n;
   int failures = 0, n_compared = 0, hi = 0;
   initial forever #12.5 sys_clk = ~sys_clk;
   // Gate input pulsed by the bench for the external count case
   timer_setup u_timer_setup (.sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .gen_timer_a_gate_clock_in(gate),
      .gen_timer_a_output(ta_o), .gen_timer_a_pin_lo_oe_n(ta_lo),
      .gen_timer_a_pin_hi_oe_n(ta_hi), .gen_timer_b_output(idle_pins[8]),
      .gen_timer_b_pin_lo_oe_n(idle_pins[7]),
      .gen_timer_b_pin_hi_oe_n(idle_pins[6]), .pwm_out(idle_pins[5:0]),
      .pwm_out_oe_n(pwm_oe_n), .irq(irq));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Handshakes are sampled at the falling edge so the decision never
   // races the design's own updates at the rising edge
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      logic at, wt, bt;
      @(posedge sys_clk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      for (int i = 0; i < 50; i++) begin
         @(negedge sys_clk);
         at = awv & awr;
         wt = wv & wrdy;
         bt = bv;
         @(posedge sys_clk);
         if (at) awv <= 0;
         if (wt) wv <= 0;
         if (bt) begin
            bry <= 0;
            chk(32'(bresp), 32'(er));
            return;
         end
      end
      failures++;
      end_sim();
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
      logic at, vt;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge sys_clk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      for (int i = 0; i < 50; i++) begin
         @(negedge sys_clk);
         at = arv & arr;
         vt = rv;
         d = rdata;
         r = rresp;
         @(posedge sys_clk);
         if (at) arv <= 0;
         if (vt) begin
            rry <= 0;
            chk(d, ed);
            chk(32'(r), 32'(er));
            return;
         end
      end
      failures++;
      end_sim();
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1;
      rd(8'h9C, 32'h0, 2'h2);
      wr(8'hA0, 32'hF, 2'h2);
      rd(8'h14, 32'h0, 2'h2);
      wr(8'h98, 32'h1, 2'h0);
      wr(8'h00, 32'h41, 2'h0);
      rd(8'h00, 32'h01, 2'h0);
      wr(8'h00, 32'h41, 2'h0);
      rd(8'h00, 32'h41, 2'h0);
      wr(8'h00, 32'h01, 2'h0);
      wr(8'h04, 32'h2, 2'h0);
      wr(8'h08, 32'h4, 2'h0);
      wr(8'h00, 32'h113B, 2'h0);
      repeat (40) begin
         @(negedge sys_clk);
         hi += int'(ta_o === 1'b1);
      end
      chk(32'(hi), 32'd5);
      chk(32'(ta_lo), 32'h0);
      rd(8'h00, 32'h39, 2'h0);
      wr(8'h98, 32'h201, 2'h0);
      @(negedge sys_clk);
      chk(32'({ta_lo, ta_hi}), 32'h2);
      rd(8'h90, 32'h201, 2'h0);
      chk(32'(irq), 32'h0);
      wr(8'h94, 32'h201, 2'h0);
      repeat (3) @(negedge sys_clk);
      chk(32'(irq), 32'h1);
      wr(8'h90, 32'h1, 2'h0);
      rd(8'h90, 32'h200, 2'h0);
      wr(8'h90, 32'h200, 2'h0);
      repeat (3) @(negedge sys_clk);
      chk(32'(irq), 32'h0);
      wr(8'h00, 32'h43, 2'h0);
      repeat (3) begin
         @(posedge sys_clk) gate <= 1;
         @(posedge sys_clk) gate <= 0;
      end
      rd(8'h0C, 32'h3, 2'h0);
      chk(32'(ta_o), 32'h1);
      wr(8'h50, 32'h01, 2'h0);
      wr(8'h50, 32'h81, 2'h0);
      rd(8'h50, 32'h01, 2'h0);
      wr(8'h20, 32'h89, 2'h0);
      rd(8'h20, 32'h89, 2'h0);
      wr(8'h24, 32'h1FFFF, 2'h0);
      rd(8'h24, 32'h1FFFF, 2'h0);
      @(negedge sys_clk);
      chk(32'(pwm_oe_n), 32'h3E);
      wr(8'h20, 32'h0, 2'h0);
      rd(8'h24, 32'h0, 2'h2);
      @(negedge sys_clk);
      chk(32'(pwm_oe_n), 32'h3F);
      chk(32'(idle_pins), 32'h0C0);
      end_sim();
   end
endmodule
